// file: hdl/snp_consts.svh
// Operation
// - Read: address, select and output low, write high
// - Sector erase: write all-ones at high supply
// - Write non-ones bytes ascending, supply high
// - Ten write loops then verify every byte
// - Failed bytes get an extra fill-in loop
// - One sector or the whole chip in one run
// - Partial sector: copy, merge, erase, rewrite; no copy or merge here, the image is loaded ready through load_in
// - Identification read: signature level raised, address bit 0 selects maker or product, rest low
`ifndef SNP_CONSTS_SVH
`define SNP_CONSTS_SVH
`define SNP_CLK_MHZ 40
`define SNP_ADDR_W 16
`define SNP_SECTOR_LSB 9
`define SNP_SECTOR_BYTES 512
`define SNP_SECTORS 128
`define SNP_ERASED_BYTE 8'hFF
`define SNP_WRITE_LOOPS 10
`define SNP_T_WP_NS 100
`define SNP_T_WP_CYC (((`SNP_T_WP_NS * `SNP_CLK_MHZ) + 999) / 1000)
`define SNP_T_SETUP_NS 50
`define SNP_T_SETUP_CYC (((`SNP_T_SETUP_NS * `SNP_CLK_MHZ) + 999) / 1000)
`define SNP_T_ACC_NS 300
`define SNP_T_ACC_CYC (((`SNP_T_ACC_NS * `SNP_CLK_MHZ) + 999) / 1000)
`define SNP_T_WC_US 150
`define SNP_T_WC_CYC (`SNP_T_WC_US * `SNP_CLK_MHZ)
`define SNP_T_VPS_US 2
`define SNP_T_VPS_CYC (`SNP_T_VPS_US * `SNP_CLK_MHZ)
`define SNP_T_ERASE_MS 500
`define SNP_T_ERASE_CYC (`SNP_T_ERASE_MS * 1000 * `SNP_CLK_MHZ)
`endif

// file: hdl/snp_pkg.sv
package snp_pkg;
   typedef enum logic [1:0] {
      SNP_CMD_PROGRAM = 2'b00,
      SNP_CMD_SECTOR_ERASE = 2'b01,
      SNP_CMD_CHIP_ERASE = 2'b10,
      SNP_CMD_READ_ID = 2'b11
   } snp_cmd_t;
endpackage : snp_pkg

// file: hdl/snp_bus_cycle.sv
`timescale 1ns/1ps
`include "snp_consts.svh"
// One strobe cycle on the device pins: write or read
module snp_bus_cycle (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic go_in,
   input wire logic write_in,
   input wire logic [7:0] wdata_in,
   input wire logic [7:0] data_bus_in,
   output logic ce_n_out,
   output logic oe_n_out,
   output logic we_n_out,
   output logic [7:0] data_bus_out,
   output logic data_bus_oe_out,
   output logic [7:0] rdata_out,
   output logic done_out
);
   typedef enum logic [1:0] {
      SNP_BC_IDLE = 2'b00,
      SNP_BC_SETUP = 2'b01,
      SNP_BC_STROBE = 2'b10,
      SNP_BC_HOLD = 2'b11
   } snp_bc_state_t;
   snp_bc_state_t state_reg;
   logic [3:0] cnt_reg;
   logic wr_reg;
   wire cnt_zero = (cnt_reg == 4'h0);
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_reg <= SNP_BC_IDLE;
         cnt_reg <= 4'h0;
         wr_reg <= 1'b0;
         ce_n_out <= 1'b1;
         oe_n_out <= 1'b1;
         we_n_out <= 1'b1;
         data_bus_out <= 8'h00;
         data_bus_oe_out <= 1'b0;
         rdata_out <= 8'h00;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         case (state_reg)
            SNP_BC_IDLE: begin
               if (go_in) begin
                  // Select asserted, output kept high for writes
                  wr_reg <= write_in;
                  ce_n_out <= 1'b0;
                  oe_n_out <= write_in;
                  data_bus_out <= wdata_in;
                  data_bus_oe_out <= write_in;
                  cnt_reg <= 4'(`SNP_T_SETUP_CYC);
                  state_reg <= SNP_BC_SETUP;
               end
            end
            SNP_BC_SETUP: begin
               if (cnt_zero) begin
                  we_n_out <= ~wr_reg;
                  cnt_reg <= wr_reg ? 4'(`SNP_T_WP_CYC) : 4'(`SNP_T_ACC_CYC);
                  state_reg <= SNP_BC_STROBE;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            SNP_BC_STROBE: begin
               // Strobe held well past the glitch filter
               if (cnt_zero) begin
                  we_n_out <= 1'b1;
                  rdata_out <= data_bus_in;
                  cnt_reg <= 4'(`SNP_T_SETUP_CYC);
                  state_reg <= SNP_BC_HOLD;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            SNP_BC_HOLD: begin
               if (cnt_zero) begin
                  ce_n_out <= 1'b1;
                  oe_n_out <= 1'b1;
                  data_bus_oe_out <= 1'b0;
                  done_out <= 1'b1;
                  state_reg <= SNP_BC_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            default: state_reg <= SNP_BC_IDLE;
         endcase
      end
   end
   a_we_in_select: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !we_n_out |-> !ce_n_out && oe_n_out)
      else $error("write strobe outside select");
   a_we_width: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $fell(we_n_out) |-> !we_n_out [*4])
      else $error("write strobe too short");
   a_data_held: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $rose(we_n_out) |-> data_bus_oe_out && $stable(data_bus_out))
      else $error("data not held at strobe rise");
   a_read_levels: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !oe_n_out |-> !ce_n_out && we_n_out && !data_bus_oe_out)
      else $error("bad read levels");
   c_write_cycle: cover property (@(posedge clk_in) $fell(we_n_out));
   c_read_cycle: cover property (@(posedge clk_in) $fell(oe_n_out));
endmodule : snp_bus_cycle

// file: hdl/snp_host.sv
`timescale 1ns/1ps
`include "snp_consts.svh"
// Host sequencer: program loops, verify, fill-in, erase, id read
module snp_host #(
   parameter int T_WC_CYC = `SNP_T_WC_CYC,
   parameter int T_VPS_CYC = `SNP_T_VPS_CYC,
   parameter int T_ERASE_CYC = `SNP_T_ERASE_CYC,
   parameter int LOOPS = `SNP_WRITE_LOOPS,
   parameter int BUF_W = 9
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic start_in,
   input wire snp_pkg::snp_cmd_t cmd_in,
   input wire logic [`SNP_ADDR_W-1:0] base_addr_in,
   input wire logic [BUF_W:0] length_in,
   input wire logic load_in,
   input wire logic [BUF_W-1:0] load_idx_in,
   input wire logic [7:0] load_data_in,
   input wire logic [7:0] data_bus_in,
   output logic [`SNP_ADDR_W-1:0] addr_out,
   output logic sig_level_out,
   output logic vpp_high_out,
   output logic ce_n_out,
   output logic oe_n_out,
   output logic we_n_out,
   output logic [7:0] data_bus_out,
   output logic data_bus_oe_out,
   output logic [7:0] id_maker_out,
   output logic [7:0] id_product_out,
   output logic busy_out,
   output logic done_out,
   output logic fail_out
);
   typedef enum logic [3:0] {
      SNP_IDLE = 4'h0,
      SNP_VPS = 4'h1,
      SNP_WRITE = 4'h2,
      SNP_WAIT = 4'h3,
      SNP_VERIFY = 4'h4,
      SNP_ERASE = 4'h5,
      SNP_ID = 4'h6,
      SNP_FINISH = 4'h7,
      SNP_SEL = 4'h8
   } snp_state_t;
   // Image of the bytes to program; loaded from outside through load_in while not busy
   logic [7:0] image_mem [0:(1<<BUF_W)-1];
   logic [(1<<BUF_W)-1:0] bad_reg;
   snp_state_t state_reg;
   snp_pkg::snp_cmd_t cmd_reg;
   logic [BUF_W-1:0] idx_reg;
   logic [BUF_W:0] len_reg;
   logic [3:0] loop_reg;
   logic [31:0] wait_reg;
   logic fill_reg, go_reg, wr_reg, any_bad_reg;
   logic [7:0] wdata_reg;
   logic [7:0] rdata;
   logic cyc_done;
   wire [7:0] cur_byte = image_mem[idx_reg];
   wire last_idx = ({1'b0, idx_reg} == len_reg - 1'b1);
   wire skip_byte = (cur_byte == `SNP_ERASED_BYTE) || (fill_reg && !bad_reg[idx_reg]);
   wire wait_zero = (wait_reg == 32'h0);
   wire [`SNP_ADDR_W-1:0] cur_addr = base_addr_in + `SNP_ADDR_W'(idx_reg);
   snp_bus_cycle u_cycle (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .go_in(go_reg),
      .write_in(wr_reg),
      .wdata_in(wdata_reg),
      .data_bus_in(data_bus_in),
      .ce_n_out(ce_n_out),
      .oe_n_out(oe_n_out),
      .we_n_out(we_n_out),
      .data_bus_out(data_bus_out),
      .data_bus_oe_out(data_bus_oe_out),
      .rdata_out(rdata),
      .done_out(cyc_done)
   );
   always_ff @(posedge clk_in) begin
      if (load_in && !busy_out) begin
         image_mem[load_idx_in] <= load_data_in;
      end
   end
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_reg <= SNP_IDLE;
         cmd_reg <= snp_pkg::SNP_CMD_PROGRAM;
         idx_reg <= '0;
         len_reg <= '0;
         loop_reg <= 4'h0;
         wait_reg <= 32'h0;
         fill_reg <= 1'b0;
         go_reg <= 1'b0;
         wr_reg <= 1'b0;
         any_bad_reg <= 1'b0;
         wdata_reg <= 8'h00;
         bad_reg <= '0;
         addr_out <= 16'h0000;
         sig_level_out <= 1'b0;
         vpp_high_out <= 1'b0;
         id_maker_out <= 8'h00;
         id_product_out <= 8'h00;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         fail_out <= 1'b0;
      end else begin
         go_reg <= 1'b0;
         done_out <= 1'b0;
         case (state_reg)
            SNP_IDLE: begin
               if (start_in) begin
                  cmd_reg <= cmd_in;
                  len_reg <= length_in;
                  idx_reg <= '0;
                  loop_reg <= 4'h0;
                  fill_reg <= 1'b0;
                  bad_reg <= '0;
                  busy_out <= 1'b1;
                  fail_out <= 1'b0;
                  if (cmd_in == snp_pkg::SNP_CMD_READ_ID) begin
                     addr_out <= 16'h0000;
                     sig_level_out <= 1'b1;
                     wr_reg <= 1'b0;
                     go_reg <= 1'b1;
                     state_reg <= SNP_ID;
                  end else if (cmd_in == snp_pkg::SNP_CMD_CHIP_ERASE) begin
                     addr_out <= base_addr_in;
                     wdata_reg <= `SNP_ERASED_BYTE;
                     wr_reg <= 1'b1;
                     go_reg <= 1'b1;
                     state_reg <= SNP_SEL;
                  end else begin
                     vpp_high_out <= 1'b1;
                     wait_reg <= 32'(T_VPS_CYC);
                     state_reg <= SNP_VPS;
                  end
               end
            end
            SNP_VPS: begin
               if (wait_zero) begin
                  wr_reg <= 1'b1;
                  if (cmd_reg == snp_pkg::SNP_CMD_PROGRAM) begin
                     state_reg <= SNP_WRITE;
                  end else begin
                     // One all-ones write, nothing after it so no abort
                     addr_out <= base_addr_in;
                     wdata_reg <= `SNP_ERASED_BYTE;
                     go_reg <= 1'b1;
                     wait_reg <= 32'(T_ERASE_CYC);
                     state_reg <= SNP_ERASE;
                  end
               end else begin
                  wait_reg <= wait_reg - 32'h1;
               end
            end
            SNP_WRITE: begin
               // Ascending order, skipping erased bytes
               if (skip_byte) begin
                  if (last_idx) begin
                     state_reg <= SNP_FINISH;
                  end else begin
                     idx_reg <= idx_reg + 1'b1;
                  end
               end else begin
                  addr_out <= cur_addr;
                  wdata_reg <= cur_byte;
                  wr_reg <= 1'b1;
                  go_reg <= 1'b1;
                  wait_reg <= 32'(T_WC_CYC);
                  state_reg <= SNP_WAIT;
               end
            end
            SNP_WAIT: begin
               // Self-timed write: wait counted from the launch of the bus cycle, so it overlaps the strobe
               if (!wait_zero) begin
                  wait_reg <= wait_reg - 32'h1;
               end else if (last_idx) begin
                  state_reg <= SNP_FINISH;
               end else begin
                  idx_reg <= idx_reg + 1'b1;
                  state_reg <= SNP_WRITE;
               end
            end
            SNP_FINISH: begin
               idx_reg <= '0;
               if (!fill_reg && loop_reg != 4'(LOOPS - 1)) begin
                  loop_reg <= loop_reg + 4'h1;
                  state_reg <= SNP_WRITE;
               end else if (!fill_reg) begin
                  addr_out <= base_addr_in;
                  wr_reg <= 1'b0;
                  go_reg <= 1'b1;
                  any_bad_reg <= 1'b0;
                  state_reg <= SNP_VERIFY;
               end else begin
                  fill_reg <= 1'b0;
                  addr_out <= base_addr_in;
                  wr_reg <= 1'b0;
                  go_reg <= 1'b1;
                  any_bad_reg <= 1'b0;
                  state_reg <= SNP_VERIFY;
               end
            end
            SNP_VERIFY: begin
               if (cyc_done) begin
                  bad_reg[idx_reg] <= (rdata != cur_byte);
                  if (rdata != cur_byte) any_bad_reg <= 1'b1;
                  if (!last_idx) begin
                     idx_reg <= idx_reg + 1'b1;
                     addr_out <= cur_addr + 16'h0001;
                     go_reg <= 1'b1;
                  end else if (any_bad_reg || rdata != cur_byte) begin
                     if (loop_reg == 4'(LOOPS)) begin
                        fail_out <= 1'b1;
                        vpp_high_out <= 1'b0;
                        busy_out <= 1'b0;
                        done_out <= 1'b1;
                        state_reg <= SNP_IDLE;
                     end else begin
                        // Fill-in pass over failing bytes only
                        loop_reg <= 4'(LOOPS);
                        fill_reg <= 1'b1;
                        idx_reg <= '0;
                        state_reg <= SNP_WRITE;
                     end
                  end else begin
                     vpp_high_out <= 1'b0;
                     busy_out <= 1'b0;
                     done_out <= 1'b1;
                     state_reg <= SNP_IDLE;
                  end
               end
            end
            SNP_ERASE: begin
               if (wait_zero) begin
                  vpp_high_out <= 1'b0;
                  busy_out <= 1'b0;
                  done_out <= 1'b1;
                  state_reg <= SNP_IDLE;
               end else begin
                  wait_reg <= wait_reg - 32'h1;
               end
            end
            SNP_ID: begin
               if (cyc_done) begin
                  if (!addr_out[0]) begin
                     id_maker_out <= rdata;
                     addr_out <= 16'h0001;
                     go_reg <= 1'b1;
                  end else begin
                     id_product_out <= rdata;
                     sig_level_out <= 1'b0;
                     addr_out <= 16'h0000;
                     busy_out <= 1'b0;
                     done_out <= 1'b1;
                     state_reg <= SNP_IDLE;
                  end
               end
            end
            SNP_SEL: begin
               // Logic-level supply write done, now raise supply
               if (cyc_done) begin
                  vpp_high_out <= 1'b1;
                  wait_reg <= 32'(T_VPS_CYC);
                  state_reg <= SNP_VPS;
               end
            end
            default: state_reg <= SNP_IDLE;
         endcase
      end
   end
   a_write_needs_vpp: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $fell(we_n_out) |-> vpp_high_out != (state_reg == SNP_SEL))
      else $error("write without high supply");
   a_no_write_ones: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $fell(we_n_out) && cmd_reg == snp_pkg::SNP_CMD_PROGRAM |-> data_bus_out != 8'hFF)
      else $error("all-ones byte programmed");
   a_erase_ones: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $fell(we_n_out) && cmd_reg != snp_pkg::SNP_CMD_PROGRAM |-> data_bus_out == 8'hFF)
      else $error("erase without all-ones data");
   a_id_levels: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      sig_level_out && !oe_n_out |-> addr_out[15:1] == 15'h0000 && !vpp_high_out)
      else $error("bad id levels");
   a_wait_cycle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_reg == SNP_WAIT && wait_zero |-> ce_n_out)
      else $error("no write wait");
   c_program_done: cover property (@(posedge clk_in) done_out && !fail_out && cmd_reg == snp_pkg::SNP_CMD_PROGRAM);
   c_fill_in: cover property (@(posedge clk_in) $rose(fill_reg));
   c_erase: cover property (@(posedge clk_in) state_reg == SNP_ERASE);
   c_id: cover property (@(posedge clk_in) done_out && cmd_reg == snp_pkg::SNP_CMD_READ_ID);
endmodule : snp_host

// file: testbench/snp_dev_model.sv
`timescale 1ns/1ps
// Behavioural byte-wide array driven through the host pins
module snp_dev_model #(
   parameter int ABORT_NS = 250000,
   parameter logic [7:0] MAKER_ID = 8'h5C, // Arbitrary value
   parameter logic [7:0] PRODUCT_ID = 8'hA7 // Arbitrary value
) (
   input wire logic [15:0] addr_in,
   input wire logic sig_level_in,
   input wire logic vpp_high_in,
   input wire logic ce_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic [7:0] data_bus_in,
   output logic [7:0] data_bus_out,
   output logic data_bus_oe_out
);
   logic [7:0] mem [0:65535];
   logic [7:0] wcnt [0:65535];
   logic [15:0] addr_q;
   logic [7:0] last_q = 8'h00;
   logic [7:0] rd_val;
   logic active = 1'b0;
   logic chip_sel = 1'b0;
   int seq = 0;
   realtime t_fall;

   assign data_bus_oe_out = !ce_n_in && !oe_n_in && we_n_in;
   assign rd_val = (sig_level_in && addr_in[15:1] == 15'h0000) ? (addr_in[0] ? PRODUCT_ID : MAKER_ID) : mem[addr_in];
   // Floating bus shows the inverse of the last byte driven
   assign data_bus_out = data_bus_oe_out ? rd_val : ~last_q;

   always @(negedge data_bus_oe_out) last_q = rd_val;

   task automatic arm_erase(input int my, input logic chip, input logic [6:0] sec);
      #(ABORT_NS);
      if (seq == my) begin
         if (chip) begin
            for (int a = 0; a < 65536; a++) mem[a] = 8'hFF;
         end else begin
            for (int c = 0; c < 512; c++) mem[{sec, c[8:0]}] = 8'hFF;
         end
         chip_sel = 1'b0;
      end
   endtask

   task automatic do_write(input logic [7:0] d);
      int my;
      logic ch;
      logic [6:0] sec;
      seq++;
      my = seq;
      ch = chip_sel;
      sec = addr_q[15:9];
      wcnt[addr_q] = wcnt[addr_q] + 8'h01;
      if (!vpp_high_in) begin
         chip_sel = 1'b1;
      end else if (d == 8'hFF) begin
         fork
            arm_erase(my, ch, sec);
         join_none
      end else begin
         mem[addr_q] = mem[addr_q] & d;
         chip_sel = 1'b0;
      end
   endtask

   always @(negedge we_n_in or negedge ce_n_in) begin
      if (!we_n_in && !ce_n_in && oe_n_in) begin
         addr_q = addr_in;
         t_fall = $realtime;
         active = 1'b1;
      end
   end

   always @(posedge we_n_in or posedge ce_n_in) begin
      if (active) begin
         active = 1'b0;
         if (oe_n_in && $realtime - t_fall >= 20.0) do_write(data_bus_in);
      end
   end
endmodule : snp_dev_model

// file: testbench/snp_host_tb.sv
`timescale 1ns/1ps
module snp_host_tb;
   localparam logic [7:0] MAKER_ID = 8'h5C; // Arbitrary value
   localparam logic [7:0] PRODUCT_ID = 8'hA7; // Arbitrary value
   typedef struct {bit cf; logic fail; bit ci; logic [15:0] id; int lo; int hi; bit cc;} snp_exp_t;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic start_in = 1'b0;
   snp_pkg::snp_cmd_t cmd_in = snp_pkg::SNP_CMD_PROGRAM;
   logic [15:0] base_addr_in = 16'h0000;
   logic [9:0] length_in = 10'h000;
   logic load_in = 1'b0;
   logic [8:0] load_idx_in = 9'h000;
   logic [7:0] load_data_in = 8'h00;
   logic [15:0] addr;
   logic sig_level, vpp_high, ce_n, oe_n, we_n, host_oe, dev_oe, busy_out, done_out, fail_out;
   logic [7:0] host_dout, dev_dout, bus, id_maker_out, id_product_out;
   logic [7:0] exp_mem [0:65535];
   logic [7:0] img [0:15];
   logic [31:0] rng = 32'h00000040;
   snp_exp_t exp_q [$];
   snp_exp_t cur;
   snp_exp_t ex;
   int failures = 0;
   int compares = 0;

   assign bus = host_oe ? host_dout : dev_dout;

   snp_host #(.T_WC_CYC(20), .T_VPS_CYC(5), .T_ERASE_CYC(50), .LOOPS(10)) i_dut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in), .cmd_in(cmd_in),
      .base_addr_in(base_addr_in), .length_in(length_in), .load_in(load_in), .load_idx_in(load_idx_in),
      .load_data_in(load_data_in), .data_bus_in(bus), .addr_out(addr), .sig_level_out(sig_level),
      .vpp_high_out(vpp_high), .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n), .data_bus_out(host_dout),
      .data_bus_oe_out(host_oe), .id_maker_out(id_maker_out), .id_product_out(id_product_out),
      .busy_out(busy_out), .done_out(done_out), .fail_out(fail_out));

   // Abort delay shortened to keep erase runs brief
   snp_dev_model #(.ABORT_NS(250), .MAKER_ID(MAKER_ID), .PRODUCT_ID(PRODUCT_ID)) i_dev (
      .addr_in(addr), .sig_level_in(sig_level), .vpp_high_in(vpp_high), .ce_n_in(ce_n), .oe_n_in(oe_n),
      .we_n_in(we_n), .data_bus_in(bus), .data_bus_out(dev_dout), .data_bus_oe_out(dev_oe));

   initial begin
      forever #12.5 clk_in = ~clk_in;
   end

   function automatic logic [7:0] rnd8();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction : rnd8

   task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk_byte

   task automatic chk_flag(input string what, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %b seen %b", what, e, g);
      end
   endtask : chk_flag

   task automatic give_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   task automatic load_img(input int len);
      for (int i = 0; i < len; i++) begin
         @(negedge clk_in);
         load_in = 1'b1;
         load_idx_in = i[8:0];
         load_data_in = img[i];
      end
      @(negedge clk_in);
      load_in = 1'b0;
   endtask : load_img

   task automatic run_op(input string name, input snp_pkg::snp_cmd_t cmd, input logic [15:0] base, input int len,
                         input bit poke, input snp_exp_t e);
      int n;
      exp_q.push_back(e);
      @(negedge clk_in);
      cmd_in = cmd;
      base_addr_in = base;
      length_in = len[9:0];
      start_in = 1'b1;
      @(negedge clk_in);
      start_in = 1'b0;
      // A second start while busy must be dropped
      if (poke) cmd_in = snp_pkg::SNP_CMD_CHIP_ERASE;
      n = 0;
      while (done_out !== 1'b1 && n < 40000) begin
         @(negedge clk_in);
         n++;
         start_in = poke && n == 30;
      end
      if (n >= 40000) failures++;
      @(negedge clk_in);
      $display("test %s done", name);
   endtask : run_op

   always @(negedge clk_in) begin
      if (done_out === 1'b1) begin
         if (exp_q.size() == 0) begin
            failures++;
            $display("Error done_out expected 0 seen 1");
         end else begin
            cur = exp_q.pop_front();
            if (cur.cf) chk_flag("fail_out", cur.fail, fail_out);
            if (cur.ci) chk_byte("id_maker_out", cur.id[15:8], id_maker_out);
            if (cur.ci) chk_byte("id_product_out", cur.id[7:0], id_product_out);
            for (int a = cur.lo; a <= cur.hi; a++) chk_byte("array byte", exp_mem[a], i_dev.mem[a]);
            for (int k = 0; k < 16 && cur.cc; k++) begin
               chk_byte("write count", img[k] == 8'hFF ? 8'h00 : 8'h0A, i_dev.wcnt[cur.lo + k]);
            end
         end
      end
   end

   initial begin
      #(25 * 60000);
      failures++;
      $display("Error watchdog expected finish seen timeout");
      give_verdict();
   end

   initial begin
      for (int a = 0; a < 65536; a++) begin
         i_dev.mem[a] = rnd8() & 8'h7F;
         exp_mem[a] = i_dev.mem[a];
         i_dev.wcnt[a] = 8'h00;
      end
      repeat (12) @(negedge clk_in);
      sys_rst_in = 1'b0;
      ex = '{0, 1'b0, 1, {MAKER_ID, PRODUCT_ID}, 1, 0, 0};
      run_op("id", snp_pkg::SNP_CMD_READ_ID, 16'h0000, 1, 0, ex);
      for (int a = 16'h0200; a < 16'h0400; a++) exp_mem[a] = 8'hFF;
      ex = '{1, 1'b0, 0, 16'h0000, 0, 16'h05FF, 0};
      run_op("sector", snp_pkg::SNP_CMD_SECTOR_ERASE, 16'h0200, 1, 0, ex);
      for (int k = 0; k < 16; k++) img[k] = rnd8();
      img[0] = 8'h3C;
      img[5] = 8'hFF;
      img[15] = 8'hFF;
      for (int k = 0; k < 16; k++) exp_mem[16'h0200 + k] = img[k];
      // Erase write counted too; restart counts for the program run
      for (int k = 0; k < 16; k++) i_dev.wcnt[16'h0200 + k] = 8'h00;
      load_img(16);
      ex = '{1, 1'b0, 0, 16'h0000, 16'h0200, 16'h020F, 1};
      run_op("program", snp_pkg::SNP_CMD_PROGRAM, 16'h0200, 16, 1, ex);
      for (int k = 0; k < 16; k++) img[k] = rnd8() & 8'hFE;
      img[0] = 8'hC3;
      for (int k = 0; k < 16; k++) exp_mem[16'h0200 + k] = exp_mem[16'h0200 + k] & img[k];
      load_img(16);
      ex = '{1, 1'b1, 0, 16'h0000, 16'h0200, 16'h020F, 0};
      run_op("refill", snp_pkg::SNP_CMD_PROGRAM, 16'h0200, 16, 0, ex);
      for (int a = 0; a < 65536; a++) exp_mem[a] = 8'hFF;
      ex = '{1, 1'b0, 0, 16'h0000, 0, 65535, 0};
      run_op("chip", snp_pkg::SNP_CMD_CHIP_ERASE, 16'h0000, 1, 0, ex);
      give_verdict();
   end
endmodule : snp_host_tb
